// ==== rtl/pcl_pkg.sv ====
// Package for the coarse phase-loss configuration block.
// It holds the register map, the field layout, the reset values and the sizes.
// Every file that uses it imports it whole.
package pcl_pkg;
	// Register byte addresses on the plain register port.
	localparam logic [7:0] PCL_ADDR_CFG    = 8'h74;
	localparam logic [7:0] PCL_ADDR_STATUS = 8'h76;
	localparam logic [7:0] PCL_ADDR_MASK   = 8'h77;
	localparam logic [7:0] PCL_ADDR_TRACK  = 8'h78;
	// Bit positions inside the configuration register.
	localparam int PCL_BIT_COARSE_EN = 7;
	localparam int PCL_BIT_WIDE_EN   = 6;
	localparam int PCL_BIT_MULTI     = 5;
	localparam int PCL_BIT_UNUSED    = 4;
	// Values after reset.
	localparam logic [7:0] PCL_CFG_RESET  = 8'h85;
	localparam logic [1:0] PCL_IRQ_RESET  = 2'h0;
	// Status bit positions: phase loss raised, tracking saturated.
	localparam int PCL_ST_LOSS = 0;
	localparam int PCL_ST_SAT  = 1;
	// Tracked drift is a signed count of unit intervals.
	localparam int PCL_CW = 13;
	localparam logic signed [12:0] PCL_CNT_MAX = 13'sh0fff;
	localparam logic [3:0] PCL_LIM_TOP = 4'h9;
	localparam logic [11:0] PCL_LIM_BASE = 12'h004;

	// Configuration register, laid out as the byte reads back.
	typedef struct packed {
		logic       coarse_en;
		logic       wide_en;
		logic       multi_cycle_phase_response;
		logic       unused;
		logic [3:0] coarse_limit;
	} pcl_cfg_t;

	// One register port request.
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pcl_req_t;
endpackage

// ==== rtl/pcl_coarse_cfg.sv ====
// Coarse phase-loss configuration register and the drift tracker it steers.
// Assumes slip pulses come from the phase detector on mclk, one cycle each,
// and a register master that never issues read and write together.
//
// Overview of operation
// - Bit 7 enables coarse loss, range from bits 3:0
// - Drift beyond limit UI reports phase loss
// - Bit 6 switches the wide-range detector
// - Bit 5 feeds multi-cycle error, else +/-360 degrees
// - Drift memory kept while bit 5 is clear and bit 6 is set
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module pcl_coarse_cfg
	import pcl_pkg::*;
(
	// Clock and reset.
	input  wire logic                    mclk,
	input  wire logic                    reset,
	// Register port.
	input  wire pcl_req_t                req,
	output logic [7:0]                   rdata,
	// Phase detector slip pulses, one unit interval each.
	input  wire logic                    slip_up,
	input  wire logic                    slip_dn,
	// Results toward the DPLL.
	output logic signed [PCL_CW-1:0]     dpll_phase_ui,
	output logic                         phase_loss,
	output logic                         wide_range_on,
	output logic                         irq
);
	// Configuration, status and mask state.
	pcl_cfg_t   cfg;
	pcl_cfg_t   next_cfg;
	logic [1:0] status;
	logic [1:0] next_status;
	logic [1:0] mask;
	logic [1:0] next_mask;
	logic [7:0] next_rdata;
	// Tracked drift and its derived values.
	logic signed [PCL_CW-1:0] cnt;
	logic signed [PCL_CW-1:0] next_cnt;
	logic [PCL_CW-1:0]        mag;
	logic [11:0]              lim;
	logic                     next_loss;
	logic                     sat_evt;

	// Every check samples on mclk and rests while reset is high.
	default clocking chk_clk @(posedge mclk);
	endclocking
	default disable iff (reset);

	// Register writes, reads and the sticky status bits.
	always_comb begin
		next_cfg    = cfg;
		next_mask   = mask;
		next_rdata  = 8'h00;
		next_status = status;
		if (req.wr && req.addr == PCL_ADDR_CFG) begin
			next_cfg        = pcl_cfg_t'(req.wdata);
			// Bit 4 holds nothing, so a write cannot set it.
			next_cfg.unused = 1'b0;
		end
		if (req.wr && req.addr == PCL_ADDR_MASK) begin
			next_mask = req.wdata[1:0];
		end
		if (req.wr && req.addr == PCL_ADDR_STATUS) begin
			next_status = status & ~req.wdata[1:0];
		end
		// Sets come last so an event in the clearing cycle survives.
		if (next_loss && !phase_loss) begin
			next_status[PCL_ST_LOSS] = 1'b1;
		end
		if (sat_evt) begin
			next_status[PCL_ST_SAT] = 1'b1;
		end
		if (req.rd) begin
			case (req.addr)
				PCL_ADDR_CFG:    next_rdata = cfg;
				PCL_ADDR_STATUS: next_rdata = {6'h00, status};
				PCL_ADDR_MASK:   next_rdata = {6'h00, mask};
				PCL_ADDR_TRACK:  next_rdata = cnt[7:0];
				// Unmapped addresses read as zero.
				default:         next_rdata = 8'h00;
			endcase
		end
	end

	// Register stage for the software-visible state.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			cfg    <= pcl_cfg_t'(PCL_CFG_RESET);
			status <= PCL_IRQ_RESET;
			mask   <= PCL_IRQ_RESET;
			rdata  <= 8'h00;
		end else begin
			cfg    <= next_cfg;
			status <= next_status;
			mask   <= next_mask;
			rdata  <= next_rdata;
		end
	end

	// Drift tracker, limit decode and loss decision.
	always_comb begin
		next_cnt = cnt;
		sat_evt  = 1'b0;
		if (!cfg.wide_en) begin
			// Without the wide detector there is no memory past one cycle.
			next_cnt = '0;
		end else if (slip_up && !slip_dn) begin
			// Count every slip so drift over many cycles is kept.
			if (cnt == PCL_CNT_MAX) begin
				sat_evt = 1'b1;
			end else begin
				next_cnt = cnt + 13'sh0001;
			end
		end else if (slip_dn && !slip_up) begin
			if (cnt == -PCL_CNT_MAX) begin
				sat_evt = 1'b1;
			end else begin
				next_cnt = cnt - 13'sh0001;
			end
		end
		// Limit grows by powers of two; codes above the top are held there.
		if (cfg.coarse_limit > PCL_LIM_TOP) begin
			lim = (PCL_LIM_BASE << PCL_LIM_TOP) - 12'h001;
		end else begin
			lim = (PCL_LIM_BASE << cfg.coarse_limit) - 12'h001;
		end
		mag = cnt[PCL_CW-1] ? PCL_CW'(-cnt) : PCL_CW'(cnt);
		// Loss only when enabled and drift exceeds the limit.
		next_loss = cfg.coarse_en && (mag > {1'b0, lim});
	end

	// Register stage for the tracker.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			cnt        <= '0;
			phase_loss <= 1'b0;
		end else begin
			cnt        <= next_cnt;
			phase_loss <= next_loss;
		end
	end

	// Multi-cycle error goes to the loop; otherwise only the in-cycle part,
	// which is zero whole UI. The count itself is kept either way.
	assign dpll_phase_ui = cfg.multi_cycle_phase_response ? cnt : '0;
	assign wide_range_on = cfg.wide_en;
	assign irq           = |(status & mask);

	// Checks. They read internal state as well as ports, so that a failure
	// points at the stage that went wrong rather than at a far symptom.

	// Register port: the unused bit, the idle read data and the wide bit.
	a_unused_reads_zero: assert property (
		(req.rd && req.addr == PCL_ADDR_CFG)
		|=> rdata[PCL_BIT_UNUSED] == 1'b0)
		else $error("Unused bit read back as one.");
	// Read data is only meaningful for one cycle; it must be zero otherwise.
	a_rdata_idle_zero: assert property (
		!req.rd |=> rdata == 8'h00)
		else $error("Read data not zero outside a read reply.");
	a_wide_write_takes: assert property (
		(req.wr && req.addr == PCL_ADDR_CFG)
		|=> wide_range_on == $past(req.wdata[PCL_BIT_WIDE_EN]))
		else $error("Wide range bit did not follow the write.");

	// Loss decision: raised past the limit, never at or under it.
	a_loss_over_limit: assert property (
		(cfg.coarse_en && mag > {1'b0, lim} && $stable(cfg))
		|=> phase_loss)
		else $error("Drift over limit did not raise loss.");
	a_loss_within_limit: assert property (
		(mag <= {1'b0, lim}) |=> !phase_loss)
		else $error("Loss raised with drift inside the limit.");
	a_loss_needs_enable: assert property (
		!$past(cfg.coarse_en) |-> !phase_loss)
		else $error("Loss raised with coarse detector off.");

	// Tracker: one step per slip in each direction, cleared when narrow.
	a_track_up_step: assert property (
		(cfg.wide_en && slip_up && !slip_dn && cnt != PCL_CNT_MAX)
		|=> cnt == $past(cnt) + 13'sh0001)
		else $error("Up slip not tracked.");
	a_track_dn_step: assert property (
		(cfg.wide_en && slip_dn && !slip_up && cnt != -PCL_CNT_MAX)
		|=> cnt == $past(cnt) - 13'sh0001)
		else $error("Down slip not tracked.");
	a_narrow_no_memory: assert property (
		!cfg.wide_en |=> cnt == '0)
		else $error("Drift kept with wide range off.");

	// Loop error and memory across the response mode.
	a_multi_error_out: assert property (
		dpll_phase_ui == (cfg.multi_cycle_phase_response ? cnt : '0))
		else $error("Loop error does not match response mode.");
	a_memory_kept: assert property (
		(cfg.wide_en && !cfg.multi_cycle_phase_response
		&& !slip_up && !slip_dn)
		|=> cnt == $past(cnt))
		else $error("Drift memory lost while idle.");

	// Sticky status and the interrupt. A clear in the same cycle as a new
	// event must lose, or software could miss the event entirely.
	a_status_set_wins: assert property (
		(next_loss && !phase_loss) |=> status[PCL_ST_LOSS])
		else $error("Loss event did not set its status bit.");
	a_sat_sets_status: assert property (
		sat_evt |=> status[PCL_ST_SAT])
		else $error("Saturation did not set its status bit.");
	// A mask write in the event cycle may legally hide the event.
	a_irq_from_status: assert property (
		(next_loss && !phase_loss && mask[PCL_ST_LOSS]
		&& !(req.wr && req.addr == PCL_ADDR_MASK))
		|=> irq)
		else $error("Unmasked loss gave no interrupt.");

	// Scenarios that should be reached by any useful test.
	c_loss_seen: cover property (
		$rose(phase_loss));
	c_saturate: cover property (
		sat_evt);
	c_irq_clear: cover property (
		irq ##1 !irq);
	c_multi_error: cover property (
		cfg.multi_cycle_phase_response && dpll_phase_ui != '0);
	c_drift_kept: cover property (
		!cfg.multi_cycle_phase_response && cfg.wide_en && cnt != '0);
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the coarse phase-loss configuration block.
// The bench drives the register port and the slip pulses directly.
`timescale 1ns/10ps
`default_nettype none
module testbench
	import pcl_pkg::*;
;
	// Stimulus toward the block.
	logic               mclk = 1'b0;
	logic               reset = 1'b1;
	pcl_req_t           req = '0;
	logic               slip_up = 1'b0;
	logic               slip_dn = 1'b0;
	// Outputs under test.
	logic [7:0]         rdata;
	logic signed [12:0] dpll_phase_ui;
	logic               phase_loss;
	logic               wide_range_on;
	logic               irq;
	// Verdict counters.
	int                 miscompares = 0;
	int                 checked = 0;

	// Half period of 2.5 ns gives the 200 MHz clock.
	always #2.5 mclk = ~mclk;

	pcl_coarse_cfg pcl_coarse_cfg_inst (
		.mclk(mclk), .reset(reset), .req(req), .rdata(rdata),
		.slip_up(slip_up), .slip_dn(slip_dn), .dpll_phase_ui(dpll_phase_ui),
		.phase_loss(phase_loss), .wide_range_on(wide_range_on), .irq(irq)
	);

	// Counts one comparison and reports a mismatch at once.
	task automatic chk(input logic [12:0] got, input logic [12:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One write strobe; its effect is visible just after the taking edge.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge mclk);
		req <= '0;
		#1;
	endtask

	// One read strobe; data stands only in the following cycle.
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge mclk);
		req <= '0;
		#1;
		chk({5'h00, rdata}, {5'h00, e});
	endtask

	// Back-to-back slip pulses, then two edges so loss and status settle.
	task automatic slip(input logic up, input int n);
		repeat (n) begin
			@(posedge mclk);
			slip_up <= up;
			slip_dn <= ~up;
		end
		@(posedge mclk);
		slip_up <= 1'b0;
		slip_dn <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
	endtask

	// Single exit point for both the normal end and the watchdog.
	task automatic close_out;
		$display("Checked %0d, miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Main sequence; limit code 0 means a window of 3 UI.
	initial begin
		repeat (12) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		#1;
		chk(wide_range_on, 1'b0);
		rd(PCL_ADDR_CFG, PCL_CFG_RESET);
		rd(8'h75, 8'h00);
		wr(PCL_ADDR_CFG, 8'hff);
		chk(wide_range_on, 1'b1);
		rd(PCL_ADDR_CFG, 8'hef);
		wr(PCL_ADDR_CFG, 8'h20);
		chk(wide_range_on, 1'b0);
		slip(1'b1, 5);
		rd(PCL_ADDR_TRACK, 8'h00);
		wr(PCL_ADDR_MASK, 8'h00);
		wr(PCL_ADDR_CFG, 8'he0);
		slip(1'b1, 3);
		chk(phase_loss, 1'b0);
		chk(dpll_phase_ui, 13'h0003);
		slip(1'b1, 1);
		chk(phase_loss, 1'b1);
		chk(irq, 1'b0);
		rd(PCL_ADDR_STATUS, 8'h01);
		wr(PCL_ADDR_MASK, 8'h01);
		chk(irq, 1'b1);
		wr(PCL_ADDR_STATUS, 8'h01);
		chk(irq, 1'b0);
		rd(PCL_ADDR_STATUS, 8'h00);
		slip(1'b0, 1);
		chk(phase_loss, 1'b0);
		wr(PCL_ADDR_CFG, 8'hc0);
		chk(dpll_phase_ui, 13'h0000);
		rd(PCL_ADDR_TRACK, 8'h03);
		wr(PCL_ADDR_CFG, 8'h40);
		slip(1'b1, 1);
		chk(phase_loss, 1'b0);
		rd(PCL_ADDR_TRACK, 8'h04);
		// From 4, 4091 slips reach the top of 4095; the last one saturates.
		slip(1'b1, 4092);
		rd(PCL_ADDR_STATUS, 8'h02);
		chk(irq, 1'b0);
		rd(PCL_ADDR_TRACK, 8'hff);
		wr(PCL_ADDR_CFG, 8'h60);
		chk(dpll_phase_ui, 13'h0fff);
		wr(PCL_ADDR_MASK, 8'h02);
		chk(irq, 1'b1);
		wr(PCL_ADDR_STATUS, 8'h02);
		chk(irq, 1'b0);
		// The tracker clears one edge after the wide bit drops.
		wr(PCL_ADDR_CFG, 8'h20);
		rd(PCL_ADDR_TRACK, 8'h00);
		chk(dpll_phase_ui, 13'h0000);
		close_out;
	end

	// Watchdog: the sequence needs about 4200 cycles, 10000 is ample.
	initial begin
		#50000;
		miscompares++;
		close_out;
	end
endmodule
`default_nettype wire
